// ==== src/wff_pkg.sv ====
package wff_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [3:0] IDX_MASK0  = 4'h1;
	localparam logic [3:0] IDX_MASK3  = 4'h4;
	localparam logic [3:0] IDX_CRC01  = 4'h5;
	localparam logic [3:0] IDX_CRC23  = 4'h6;
	localparam logic [3:0] IDX_OFST   = 4'h7;
	localparam logic [3:0] IDX_LAST   = 4'h8;
	localparam logic [3:0] IDX_CMD    = 4'h9;
	localparam logic [3:0] IDX_WAKE   = 4'hA;
	localparam logic [3:0] IDX_PMR    = 4'hB;
	localparam int         ADDR_LSB   = 2;
	localparam int         NUM_FILT   = 4;
	localparam int         MASK_BITS  = 32;
	// Field layout of the command word.
	localparam int         CMD_W      = 4;
	localparam int         CMD_EN     = 0;
	localparam int         CMD_DA     = 1;
	localparam int         CMD_MC     = 2;
	localparam int         CSCD_LSB   = 16;
	localparam logic [31:0] CMD_WMASK = 32'h0007_7777;
	// Wake control bits.
	localparam int         WAKE_EN    = 1;
	localparam int         WAKE_FLAG  = 5;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	// Pattern checksum.
	localparam logic [15:0] CRC_POLY  = 16'h8005;
	localparam logic [15:0] CRC_INIT  = 16'hFFFF;
	localparam logic [1:0]  PTR_LAST  = 2'h3;

	// One received frame byte with its framing marks.
	typedef struct packed {
		logic       valid;
		logic       first;
		logic       last;
		logic [7:0] data;
	} wff_byte_s;

	// Address classification of the frame being received.
	typedef struct packed {
		logic destHit;
		logic mcastHit;
	} wff_hit_s;
endpackage

// ==== src/wff_filter_bank.sv ====
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module wff_filter_bank (
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [5:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire wff_pkg::wff_byte_s  rxByte,
	input  wire wff_pkg::wff_hit_s   rxHit,
	output logic                     frameWakeFlag,
	output logic      [3:0]          filterMatch
);
	import wff_pkg::*;

	// Configuration, wake, frame walk and bus state.
	logic [31:0]          mask_q [NUM_FILT];
	logic [31:0]          mask_d [NUM_FILT];
	logic [31:0]          crc01_q, crc01_d, crc23_q, crc23_d;
	logic [31:0]          ofst_q, ofst_d, last_q, last_d, cmd_q, cmd_d;
	logic [1:0]           ptr_q, ptr_d;
	logic                 wakeEn_q, wakeEn_d, flag_q, flag_d;
	logic [7:0]           pmr_q, pmr_d;
	logic [31:0]          rdata_d;
	logic [31:0]          prdata_d;
	logic                 err_d;
	logic [10:0]          cnt_q, cnt_d;
	logic [15:0]          run_q [NUM_FILT];
	logic [15:0]          run_d [NUM_FILT];
	logic [3:0]           match_q, match_d;
	logic                 wrAcc, rdAcc;
	logic [3:0]           idx;
	logic [3:0]           raw;

	// One step of the pattern checksum over a byte, MSB first.
	// The running value starts from all ones at the first frame byte.
	function automatic logic [15:0] crcStep(input logic [15:0] c,
	                                        input logic [7:0]  b);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ b[i]) begin
				r = {r[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	// Places a byte into a word at the lane given by the fill pointer.
	function automatic logic [31:0] putByte(input logic [31:0] w,
	                                        input logic [1:0]  p,
	                                        input logic [7:0]  b);
		logic [31:0] r;
		r = w;
		r[{p, 3'b000} +: 8] = b;
		return r;
	endfunction

	// Stored checksum of filter n from its shared register.
	function automatic logic [15:0] storedCrc(input int n,
	                                          input logic [31:0] a,
	                                          input logic [31:0] b);
		logic [31:0] w;
		w = (n < 2) ? a : b;
		return (n % 2 == 0) ? w[15:0] : w[31:16];
	endfunction

	// Filter number served by a byte-mask register index.
	function automatic logic [1:0] maskLane(input logic [3:0] i);
		logic [3:0] d;
		d = i - IDX_MASK0;
		return d[1:0];
	endfunction

	// Bus decode: register index, write access and read setup cycle.
	assign idx    = paddr[5:ADDR_LSB];
	assign wrAcc  = psel && penable && pwrite;
	assign rdAcc  = psel && !penable && !pwrite;
	assign pready = 1'b1;

	// Filter configuration: byte assembly through the shared fill pointer.
	always_comb begin
		for (int n = 0; n < NUM_FILT; n++) begin
			mask_d[n] = mask_q[n];
		end
		crc01_d  = crc01_q;
		crc23_d  = crc23_q;
		ofst_d   = ofst_q;
		last_d   = last_q;
		cmd_d    = cmd_q;
		ptr_d    = ptr_q;
		// One pointer serves every filter register, so word loads must not
		// be interleaved; indices A and B leave it where it is.
		if (wrAcc && idx >= IDX_MASK0 && idx <= IDX_CMD) begin
			ptr_d = (ptr_q == PTR_LAST) ? 2'h0 : ptr_q + 2'h1;
			unique case (idx)
				IDX_CRC01: crc01_d = putByte(crc01_q, ptr_q, pwdata[7:0]);
				IDX_CRC23: crc23_d = putByte(crc23_q, ptr_q, pwdata[7:0]);
				IDX_OFST:  ofst_d = putByte(ofst_q, ptr_q, pwdata[7:0]);
				IDX_LAST:  last_d = putByte(last_q, ptr_q, pwdata[7:0]);
				IDX_CMD: begin
					cmd_d = putByte(cmd_q, ptr_q, pwdata[7:0]) & CMD_WMASK;
				end
				default: begin
					mask_d[maskLane(idx)] = putByte(mask_q[maskLane(idx)],
						ptr_q, pwdata[7:0]);
				end
			endcase
		end
	end

	// Wake control, power management byte and the sticky wake flag.
	// A match in the same cycle as a clearing write leaves the flag set.
	always_comb begin
		wakeEn_d = wakeEn_q;
		pmr_d    = pmr_q;
		flag_d   = flag_q;
		if (wrAcc && idx == IDX_WAKE) begin
			wakeEn_d = pwdata[WAKE_EN];
			if (pwdata[WAKE_FLAG]) begin
				flag_d = 1'b0;
			end
		end
		if (wrAcc && idx == IDX_PMR) begin
			pmr_d  = pwdata[7:0];
			flag_d = 1'b0;
		end
		if (|match_d) begin
			flag_d = 1'b1;
		end
	end

	// Read data and error answer for the addressed register; unmapped
	// indices answer with an error and read as zero.
	always_comb begin
		rdata_d = RST_WORD;
		err_d   = 1'b0;
		unique case (idx)
			IDX_CRC01: rdata_d = crc01_q;
			IDX_CRC23: rdata_d = crc23_q;
			IDX_OFST:  rdata_d = ofst_q;
			IDX_LAST:  rdata_d = last_q;
			IDX_CMD:   rdata_d = cmd_q;
			IDX_WAKE: begin
				rdata_d[WAKE_EN]   = wakeEn_q;
				rdata_d[WAKE_FLAG] = flag_q;
			end
			IDX_PMR:   rdata_d = {24'h00_0000, pmr_q};
			default: begin
				if (idx >= IDX_MASK0 && idx <= IDX_MASK3) begin
					rdata_d = mask_q[maskLane(idx)];
				end else begin
					err_d = 1'b1;
				end
			end
		endcase
	end

	// Read data is taken in the setup cycle and stands through the access.
	assign prdata_d = rdAcc ? rdata_d : prdata;
	assign pslverr  = psel && penable && err_d;

	// Frame walk: byte count, checksum of masked bytes, end-of-frame test.
	always_comb begin
		logic [10:0] pos;
		logic [10:0] start;
		logic [15:0] base;
		logic        use_b;
		logic        ok;
		pos     = 11'h000;
		start   = 11'h000;
		base    = CRC_INIT;
		use_b   = 1'b0;
		ok      = 1'b0;
		cnt_d   = cnt_q;
		match_d = 4'h0;
		raw     = 4'h0;
		for (int n = 0; n < NUM_FILT; n++) begin
			run_d[n] = run_q[n];
		end
		if (rxByte.valid) begin
			if (rxByte.first) begin
				cnt_d = 11'h001;
			end else if (cnt_q != '1) begin
				cnt_d = cnt_q + 11'h001; // Saturates on long frames.
			end
			// Byte k feeds filter n from twice its offset on, as masked.
			for (int n = 0; n < NUM_FILT; n++) begin
				start = {2'b00, ofst_q[n*8 +: 8], 1'b0};
				pos   = (rxByte.first ? 11'h000 : cnt_q) - start;
				use_b = (rxByte.first ? 11'h000 : cnt_q) >= start &&
					pos < MASK_BITS[10:0] && mask_q[n][pos[4:0]];
				base  = rxByte.first ? CRC_INIT : run_q[n];
				run_d[n] = use_b ? crcStep(base, rxByte.data) : base;
				ok = run_d[n] == storedCrc(n, crc01_q, crc23_q) &&
					cmd_q[n*CMD_W + CMD_EN] &&
					(!cmd_q[n*CMD_W + CMD_DA] || rxHit.destHit) &&
					(!cmd_q[n*CMD_W + CMD_MC] || rxHit.mcastHit);
				raw[n] = rxByte.last && ok;
			end
			// A cascaded pair matches only when both of its filters hit.
			for (int n = 0; n < NUM_FILT; n++) begin
				ok = raw[n];
				if (n > 0 && cmd_q[CSCD_LSB + n - 1]) begin
					ok = ok && raw[n-1];
				end
				if (n < NUM_FILT - 1 && cmd_q[CSCD_LSB + n]) begin
					ok = ok && raw[n+1];
				end
				match_d[n] = ok && wakeEn_q;
			end
		end
	end

	// Filter configuration registers; all clear on reset.
	// The fill pointer restarts at lane zero on every reset.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int n = 0; n < NUM_FILT; n++) begin
				mask_q[n] <= RST_WORD;
			end
			crc01_q <= RST_WORD;
			crc23_q <= RST_WORD;
			ofst_q  <= RST_WORD;
			last_q  <= RST_WORD;
			cmd_q   <= RST_WORD;
			ptr_q   <= 2'h0;
		end else begin
			for (int n = 0; n < NUM_FILT; n++) begin
				mask_q[n] <= mask_d[n];
			end
			crc01_q <= crc01_d;
			crc23_q <= crc23_d;
			ofst_q  <= ofst_d;
			last_q  <= last_d;
			cmd_q   <= cmd_d;
			ptr_q   <= ptr_d;
		end
	end

	// Wake control registers and the sticky flag.
	// Detection stays off until software sets the enable.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wakeEn_q <= 1'b0;
			pmr_q    <= RST_BYTE;
			flag_q   <= 1'b0;
		end else begin
			wakeEn_q <= wakeEn_d;
			pmr_q    <= pmr_d;
			flag_q   <= flag_d;
		end
	end

	// Frame walk state: byte count, running checksums and match pulses.
	// The count saturates so a long frame cannot wrap into the masks.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int n = 0; n < NUM_FILT; n++) begin
				run_q[n] <= CRC_INIT;
			end
			cnt_q   <= 11'h000;
			match_q <= 4'h0;
		end else begin
			for (int n = 0; n < NUM_FILT; n++) begin
				run_q[n] <= run_d[n];
			end
			cnt_q   <= cnt_d;
			match_q <= match_d;
		end
	end

	// Read data register; it only moves in the setup cycle of a read.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= RST_WORD;
		end else begin
			prdata <= prdata_d;
		end
	end

	// Outputs come straight from their registers.
	assign frameWakeFlag = flag_q;
	assign filterMatch   = match_q;
endmodule

// ==== sim/wff_filter_bank_checker.sv ====
`timescale 1ns/100ps
// Watches the register port and the wake outputs of the bank.
module wff_filter_bank_checker (
	input wire logic               clock,
	input wire logic               rst_n,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [5:0]         paddr,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire wff_pkg::wff_byte_s rxByte,
	input wire logic               frameWakeFlag,
	input wire logic [3:0]         filterMatch
);
	import wff_pkg::*;
	logic acc;
	logic bad;
	// Access phase and unmapped index decode.
	assign acc = psel && penable;
	assign bad = paddr[5:2] == 4'h0 || paddr[5:2] >= 4'hC;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence rdSetup; psel && !penable && !pwrite; endsequence
	sequence rdBad; acc && !pwrite && bad; endsequence
	no_wait_a: assert property (acc |-> pready)
		else $error("wait state inserted");
	unmapped_err_a: assert property (acc && bad |-> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc && !bad |-> !pslverr)
		else $error("mapped access refused");
	unmapped_zero_a: assert property (rdSetup ##1 rdBad |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	read_hold_a: assert property (!(psel && !penable && !pwrite)
		|=> $stable(prdata))
		else $error("read data moved");
	match_cause_a: assert property (filterMatch != 4'h0
		|-> $past(rxByte.valid && rxByte.last))
		else $error("match without frame end");
	flag_set_a: assert property (filterMatch != 4'h0 |-> frameWakeFlag)
		else $error("flag not set on match");
	flag_rise_a: assert property ($rose(frameWakeFlag) |-> filterMatch != 4'h0)
		else $error("flag rose without match");
	flag_hold_a: assert property (frameWakeFlag && !(acc && pwrite)
		|=> frameWakeFlag)
		else $error("flag cleared without write");
endmodule
bind wff_filter_bank wff_filter_bank_checker chk (.clock, .rst_n, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .rxByte,
	.frameWakeFlag, .filterMatch);

// ==== sim/wff_apb_host.sv ====
`timescale 1ns/100ps
// Host on the register bus; issues whole transfers.
module wff_apb_host (
	input  wire logic        clock,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [5:0]  paddr,
	output logic      [31:0] pwdata,
	output logic             hung
);
	// Bus idles low until the first transfer.
	initial {psel, penable, pwrite, paddr, pwdata, hung} = '0;
	// Setup, then access held until pready is sampled high.
	task automatic xfer(input logic w, input logic [3:0] idx,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (!pready && ++n < 20);
		hung |= !pready;
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// A word goes in as four byte writes, low byte first.
	task automatic wr32(input logic [3:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		for (int k = 0; k < 4; k++) xfer(1'h1, idx, 32'(d[8*k +: 8]), r, e);
	endtask
endmodule

// ==== sim/test_wakeup_frame_filter_config.sv ====
`timescale 1ns/100ps
module test_wakeup_frame_filter_config;
	import wff_pkg::*;
	logic        clock, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        hung, frameWakeFlag, e;
	logic [5:0]  paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic [3:0]  filterMatch, seen;
	wff_byte_s   rxByte;
	wff_hit_s    rxHit;
	int          bad_count, comparisons;
	// Free-running 4 ns clock.
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end
	wff_filter_bank uut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rxByte, .rxHit,
		.frameWakeFlag, .filterMatch);
	wff_apb_host host (.clock, .prdata, .pready, .pslverr, .psel,
		.penable, .pwrite, .paddr, .pwdata, .hung);
	// Counts every compare and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Checksum of one byte, most significant bit first.
	function automatic logic [15:0] crc(input logic [7:0] b);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 7; i >= 0; i--)
			c = {c[14:0], 1'h0} ^ (c[15] ^ b[i] ? 16'h8005 : 16'h0);
		return c;
	endfunction
	// Sends four bytes with b at position p and gathers match pulses.
	task automatic frame(input logic [7:0] b, input int p);
		seen = 4'h0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clock);
			rxByte <= '{1'h1, k == 0, k == 3, k == p ? b : 8'($urandom)};
		end
		@(posedge clock);
		rxByte <= '0;
		repeat (4) begin
			@(posedge clock);
			seen |= filterMatch;
		end
	endtask
	// Main sequence.
	initial begin
		rxByte = '0;
		rxHit  = '0;
		rst_n = 1'h0;
		void'($urandom(32'hD4BC));
		repeat (12) @(posedge clock);
		rst_n <= 1'h1;
		for (int i = 0; i < 16; i++) begin
			host.xfer(1'h0, 4'(i), 32'h0, r, e);
			chk(r, 32'h0);
			chk(32'(e), 32'(i == 0 || i > 11));
		end
		for (int i = 1; i < 10; i++) begin
			v = $urandom;
			host.wr32(4'(i), v);
			host.xfer(1'h0, 4'(i), 32'h0, r, e);
			chk(r, i == 9 ? v & CMD_WMASK : v);
		end
		v = $urandom;
		host.wr32(IDX_MASK0, 32'h1);
		host.wr32(IDX_OFST, 32'h0);
		host.wr32(IDX_CRC01, 32'(crc(v[7:0])));
		host.wr32(IDX_CMD, 32'h1);
		frame(v[7:0], 0);
		chk(32'(seen), 32'h0);
		host.xfer(1'h1, IDX_WAKE, 32'h2, r, e);
		frame(v[7:0], 0);
		chk(32'(seen), 32'h1);
		chk(32'(frameWakeFlag), 32'h1);
		frame(~v[7:0], 0);
		chk(32'(seen), 32'h0);
		host.xfer(1'h1, IDX_WAKE, 32'h22, r, e);
		@(posedge clock);
		chk(32'(frameWakeFlag), 32'h0);
		host.wr32(IDX_OFST, 32'h1);
		frame(v[7:0], 2);
		chk(32'(seen), 32'h1);
		host.xfer(1'h1, IDX_PMR, 32'h0, r, e);
		@(posedge clock);
		chk(32'(frameWakeFlag), 32'h0);
		host.wr32(IDX_CMD, 32'h5);
		frame(v[7:0], 2);
		chk(32'(seen), 32'h0);
		rxHit <= '{1'h0, 1'h1};
		frame(v[7:0], 2);
		chk(32'(seen), 32'h1);
		host.wr32(IDX_CMD, 32'h3);
		frame(v[7:0], 2);
		chk(32'(seen), 32'h0);
		rxHit <= '{1'h1, 1'h0};
		frame(v[7:0], 2);
		chk(32'(seen), 32'h1);
		host.wr32(IDX_CMD, 32'h1_0001);
		frame(v[7:0], 2);
		chk(32'(seen), 32'h0);
		host.wr32(IDX_MASK0 + 4'h1, 32'h1);
		host.wr32(IDX_OFST, 32'h101);
		host.wr32(IDX_CRC01, {2{crc(v[7:0])}});
		host.wr32(IDX_CMD, 32'h1_0011);
		frame(v[7:0], 2);
		chk(32'(seen), 32'h3);
		// A lone byte write, then a reset: the fill pointer must restart.
		host.xfer(1'h1, IDX_LAST, 32'hA5, r, e);
		rst_n <= 1'h0;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		chk(32'(frameWakeFlag), 32'h0);
		host.xfer(1'h0, IDX_CMD, 32'h0, r, e);
		chk(r, 32'h0);
		v = $urandom;
		host.wr32(IDX_LAST, v);
		host.xfer(1'h0, IDX_LAST, 32'h0, r, e);
		chk(r, v);
		chk(32'(hung), 32'h0);
		end_of_test();
	end
endmodule
